//--- rtl/grouped_irq_combiner.sv
/*
  grouped interrupt combiner: member flags feed up to three grouped
  request flags, which vector the core in fixed priority order.
  assumes an avalon-mm master on sys_clk and a core that acknowledges
  vectors and signals return-from-irq with a one-cycle pulse.
*/
// Behaviour
// - three grouped channels, own flag, own vector
// - group requests come only from member sources
// - request asserted while any group flag set
// - group flag set by enabled member flag set
// - enabled group, stack room: call its vector
// - servicing clears serviced group flag
// - servicing clears global interrupt enable
// - vector needs global, member and group enables
// - timer matches set period and compare flags
// - any flag rise raises a wake-up
// - return-from-irq sets global enable again
`timescale 1ns/1ns
`include "grouped_irq_cfg.svh"
module grouped_irq_combiner #(
  parameter int NGRP   = 3,
  parameter int NTIMER = 3,
  parameter int NSRC   = 2 * NTIMER + 2
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // avalon-mm slave
  input  wire logic [7:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // member source events, asynchronous pins
  input  wire logic [NTIMER-1:0]    timerPeriodMatch,
  input  wire logic [NTIMER-1:0]    timerCompareMatch,
  input  wire logic                 lowSupplyDetect,
  input  wire logic                 nvWriteDone,
  // core sequencer side
  input  wire logic                 stackFull,
  input  wire logic                 vectorAck,
  input  wire logic                 returnFromIrqInstr,
  input  wire logic                 returnPlain,
  output logic                      groupIrqReq,
  output logic                      vectorReq,
  output logic      [15:0]          vectorAddr,
  output logic                      wakeUp,
  output logic                      irqOut
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int GW = $clog2(NGRP);
  // gw is the width of a group index; three groups need two bits

  logic [NSRC-1:0]      evtMeta_q;     // first sync stage
  logic [NSRC-1:0]      evtSync_q;     // second sync stage
  logic [NSRC-1:0]      evtPrev_q;     // for edge detect
  logic [NSRC-1:0]      srcEvent;      // one-cycle event pulse
  logic [NSRC-1:0]      srcEn_q;       // member enables
  logic [NSRC-1:0]      swClear;       // member flag clear strobe
  logic [NSRC-1:0]      swSet;         // member flag set strobe
  logic [NGRP-1:0]      grpFlag_q;     // grouped request flags
  logic [NGRP-1:0]      grpEn_q;       // grouped channel enables
  logic [2*NSRC-1:0]    map_q;         // group index per member
  logic                 gie_q;         // global interrupt enable
  logic [NGRP-1:0]      grpSet;        // group flag set terms
  logic [NGRP-1:0]      grpEligible;   // groups allowed to vector
  logic [GW-1:0]        pickIdx;       // highest priority group
  logic                 pickValid;     // any eligible group
  logic [GW-1:0]        svcIdx_q;      // group under service
  logic [15:0]          vecAddr_q;     // vector address register
  logic                 wakeStat_q;    // sticky wake-up status
  logic                 wakeMask_q;    // wake interrupt mask
  logic                 wakePulse;     // any flag rise
  logic                 svcTake;       // vector acknowledged
  logic                 wrHit;         // register write
  logic                 rdPend_q;      // read answered next cycle
  logic [31:0]          rdData_d;      // read mux output
  logic [31:0]          rdData_q;      // registered read data
  logic [31:0]          wMask;         // byte enable mask
  grouped_irq_pkg::seq_state_type state_q;
  grouped_irq_pkg::seq_state_type state_d;

  member_flags_if #(.NSRC(NSRC)) mf ();

  // ****************************************************************
  // pin synchronisers and event edge detect
  // ****************************************************************
  // double flop all asynchronous source lines
  // the pins are levels from other clock domains, so nothing but the
  // second stage reads the first; the third stage only remembers
  // the synced level for edge detection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evtMeta_q <= '0;
      evtSync_q <= '0;
      evtPrev_q <= '0;
    end else begin
      evtMeta_q <= {nvWriteDone, lowSupplyDetect,
                    timerCompareMatch, timerPeriodMatch};
      evtSync_q <= evtMeta_q;
      evtPrev_q <= evtSync_q;
    end
  end

  // a match or detect event is its rising edge
  // a level held high for many cycles counts once, so a stuck
  // comparator cannot keep re-setting a cleared member flag
  assign srcEvent = evtSync_q & ~evtPrev_q;

  // ****************************************************************
  // member flag bank
  // ****************************************************************
  // sticky member flags; an event wins over a clear in one cycle
  member_flag_bank #(
    .NSRC(NSRC)
  ) u_bank (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .srcEvent(srcEvent),
    .swClear (swClear),
    .swSet   (swSet),
    .mf      (mf.bank)
  );

  // ****************************************************************
  // avalon-mm slave: fixed one-wait read, zero-wait write
  // ****************************************************************
  assign wMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wrHit = write;
  // read waits one cycle so data come from a flop
  // writes never wait: a write is taken at the edge it is seen
  assign waitrequest = read & ~rdPend_q;

  // read pending toggle
  // high only in the second cycle of a read, so a held read
  // starts a fresh access after each answer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPend_q <= 1'b0;
    end else begin
      rdPend_q <= read & ~rdPend_q;
    end
  end

  // member flag write strobes: write one clears, set strobe tied low
  assign swClear = (wrHit && address == `OFS_SRC_FLAG) ?
                   writedata[NSRC-1:0] & wMask[NSRC-1:0] : '0;
  // no software set path: member flags rise only from events, so a
  // bus write can never force a flag high
  assign swSet   = '0;

  // read mux, unmapped reads zero
  // the service register shows the vector of the group last taken
  always_comb begin
    rdData_d = 32'h0000_0000;
    case (address)
      `OFS_CTRL:      rdData_d[`CTRL_GIE_BIT] = gie_q;
      `OFS_GRP_FLAG:  rdData_d[NGRP-1:0] = grpFlag_q;
      `OFS_GRP_EN:    rdData_d[NGRP-1:0] = grpEn_q;
      `OFS_SRC_FLAG:  rdData_d[NSRC-1:0] = mf.flags;
      `OFS_SRC_EN:    rdData_d[NSRC-1:0] = srcEn_q;
      `OFS_MAP:       rdData_d[2*NSRC-1:0] = map_q;
      `OFS_SVC:       rdData_d[15:0] = vecAddr_q;
      `OFS_WAKE_STAT: rdData_d[`WAKE_EVT_BIT] = wakeStat_q;
      `OFS_WAKE_MASK: rdData_d[`WAKE_EVT_BIT] = wakeMask_q;
      default:        rdData_d = 32'h0000_0000;
    endcase
  end

  // registered read data
  // loaded in the first cycle of a read, held until the next read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 32'h0000_0000;
    end else if (read && !rdPend_q) begin
      rdData_q <= rdData_d;
    end
  end
  assign readdata = rdData_q;

  // enable and map registers
  // byte lanes mask each field; unmapped offsets are ignored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grpEn_q    <= '0;
      srcEn_q    <= '0;
      map_q      <= (2*NSRC)'(`MAP_RESET);
      wakeMask_q <= 1'b0;
    end else if (wrHit) begin
      case (address)
        `OFS_GRP_EN:
          grpEn_q <= (grpEn_q & ~wMask[NGRP-1:0]) |
                     (writedata[NGRP-1:0] & wMask[NGRP-1:0]);
        `OFS_SRC_EN:
          srcEn_q <= (srcEn_q & ~wMask[NSRC-1:0]) |
                     (writedata[NSRC-1:0] & wMask[NSRC-1:0]);
        `OFS_MAP:
          map_q <= (map_q & ~wMask[2*NSRC-1:0]) |
                   (writedata[2*NSRC-1:0] & wMask[2*NSRC-1:0]);
        `OFS_WAKE_MASK:
          if (byteenable[0]) begin
            wakeMask_q <= writedata[`WAKE_EVT_BIT];
          end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // grouped request flags
  // ****************************************************************
  genvar g;
  for (g = 0; g < NGRP; g++) begin : g_grp
    logic [NSRC-1:0] member;  // members mapped to this group
    genvar s;
    for (s = 0; s < NSRC; s++) begin : g_mem
      assign member[s] = (map_q[2*s +: 2] == 2'(g));
    end
    // set only by a rising, enabled member flag
    // a member already set when its enable rises does not count
    assign grpSet[g] = |(mf.rising & srcEn_q & member);

    // set wins over service clear and software clear
    // software clears a group flag by writing a one to its bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        grpFlag_q[g] <= 1'b0;
      end else if (grpSet[g]) begin
        grpFlag_q[g] <= 1'b1;
      end else if (svcTake && svcIdx_q == GW'(g)) begin
        grpFlag_q[g] <= 1'b0;
      end else if (wrHit && address == `OFS_GRP_FLAG &&
                   byteenable[0] && writedata[g]) begin
        grpFlag_q[g] <= 1'b0;
      end
    end
    // vector needs group enable, global enable, stack room
    assign grpEligible[g] = grpFlag_q[g] & grpEn_q[g];
  end

  assign groupIrqReq = |grpFlag_q;

  // fixed priority, lowest index wins
  // the loop runs from the top, so the last hit is the lowest
  always_comb begin
    pickIdx   = '0;
    pickValid = 1'b0;
    for (int k = NGRP - 1; k >= 0; k--) begin
      if (grpEligible[k]) begin
        pickIdx   = GW'(k);
        pickValid = 1'b1;
      end
    end
  end

  // ****************************************************************
  // vector sequencer
  // ****************************************************************
  assign svcTake = (state_q == grouped_irq_pkg::SEQ_VECTOR) && vectorAck;

  // next state
  // idle waits for an eligible group, global enable and stack room;
  // serve waits for either kind of return from the core
  always_comb begin
    state_d = state_q;
    case (state_q)
      grouped_irq_pkg::SEQ_IDLE:
        if (pickValid && gie_q && !stackFull) begin
          state_d = grouped_irq_pkg::SEQ_VECTOR;
        end
      grouped_irq_pkg::SEQ_VECTOR:
        if (vectorAck) begin
          state_d = grouped_irq_pkg::SEQ_SERVE;
        end
      grouped_irq_pkg::SEQ_SERVE:
        if (returnFromIrqInstr || returnPlain) begin
          state_d = grouped_irq_pkg::SEQ_IDLE;
        end
      default: state_d = grouped_irq_pkg::SEQ_IDLE;
    endcase
  end

  // state register and captured channel and vector
  // index and vector are frozen when the request rises, so they
  // stand unchanged until the core acknowledges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= grouped_irq_pkg::SEQ_IDLE;
      svcIdx_q  <= '0;
      vecAddr_q <= `VEC_BASE;
    end else begin
      state_q <= state_d;
      if (state_q == grouped_irq_pkg::SEQ_IDLE &&
          state_d == grouped_irq_pkg::SEQ_VECTOR) begin
        svcIdx_q  <= pickIdx;
        // each channel its own vector
        vecAddr_q <= `VEC_BASE + 16'(pickIdx) * `VEC_STEP;
      end
    end
  end

  assign vectorReq  = (state_q == grouped_irq_pkg::SEQ_VECTOR);
  assign vectorAddr = vecAddr_q;

  // global enable: software write, cleared on service, set by return
  // a plain return leaves it as the service left it, cleared
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gie_q <= 1'(`CTRL_RESET);
    end else if (svcTake) begin
      gie_q <= 1'b0;
    end else if (returnFromIrqInstr) begin
      gie_q <= 1'b1;
    end else if (wrHit && address == `OFS_CTRL && byteenable[0]) begin
      gie_q <= writedata[`CTRL_GIE_BIT];
    end
  end

  // ****************************************************************
  // wake-up and bus interrupt
  // ****************************************************************
  // any flag rise wakes regardless of enables
  // the group term is the rise of a group flag, one edge early
  assign wakePulse = (|mf.rising) | (|grpSet);
  assign wakeUp    = wakePulse;

  // sticky wake status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeStat_q <= 1'b0;
    end else if (wakePulse) begin
      wakeStat_q <= 1'b1;
    end else if (wrHit && address == `OFS_WAKE_STAT && byteenable[0] &&
                 writedata[`WAKE_EVT_BIT]) begin
      wakeStat_q <= 1'b0;
    end
  end

  // level interrupt while the unmasked wake status stands
  assign irqOut = wakeStat_q & wakeMask_q;
endmodule

//--- rtl/grouped_irq_cfg.svh
/*
  constants for the grouped interrupt combiner: register offsets,
  field positions, reset values and vector addresses.
  assumes inclusion by bare name from the rtl files.
*/
`ifndef GROUPED_IRQ_CFG_SVH
`define GROUPED_IRQ_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_GRP_FLAG    8'h04
`define OFS_GRP_EN      8'h08
`define OFS_SRC_FLAG    8'h0C
`define OFS_SRC_EN      8'h10
`define OFS_MAP         8'h14
`define OFS_SVC         8'h18
`define OFS_WAKE_STAT   8'h1C
`define OFS_WAKE_MASK   8'h20

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_GIE_BIT    0
`define CTRL_RESET      32'h0000_0000
`define MAP_RESET       32'h0000_0000
`define WAKE_EVT_BIT    0
`define VEC_BASE        16'h000C
`define VEC_STEP        16'h0004

`endif

//--- rtl/grouped_irq_pkg.sv
/*
  types shared by the combiner files.
  assumes nothing of its surroundings.
*/
package grouped_irq_pkg;
  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b001,
    SEQ_VECTOR = 3'b010,
    SEQ_SERVE  = 3'b100
  } seq_state_type;
endpackage

//--- rtl/member_flags_if.sv
/*
  interface carrying member source flags from the source bank to the
  combiner core.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
interface member_flags_if #(
  parameter int NSRC = 8
);
  logic [NSRC-1:0] flags;   // member request flags
  logic [NSRC-1:0] rising;  // one-cycle pulse on each flag rise
  modport bank (output flags, output rising);
  modport core (input flags, input rising);
endinterface

//--- rtl/member_flag_bank.sv
/*
  sticky member request flags for timer, low-supply and nv-write
  sources; set by synchronised events, cleared by software write.
  assumes event inputs are already in the sys_clk domain.
*/
`timescale 1ns/1ns
module member_flag_bank #(
  parameter int NSRC = 8
) (
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire logic [NSRC-1:0] srcEvent,
  input  wire logic [NSRC-1:0] swClear,
  input  wire logic [NSRC-1:0] swSet,
  member_flags_if.bank         mf
);
  logic [NSRC-1:0] flag_q;  // sticky flags
  logic [NSRC-1:0] prev_q;  // flags one cycle earlier

  // ****************************************************************
  // per-flag sticky bit, set wins over clear
  // ****************************************************************
  genvar i;
  for (i = 0; i < NSRC; i++) begin : g_flag
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        flag_q[i] <= 1'b0;
      end else if (srcEvent[i] || swSet[i]) begin
        flag_q[i] <= 1'b1;
      end else if (swClear[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

  // previous value for edge detection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= flag_q;
    end
  end

  assign mf.flags  = flag_q;
  assign mf.rising = flag_q & ~prev_q;
endmodule

//--- verif/grouped_irq_combiner_chk.sv
/*
  concurrent checks on the combiner's core-side ports.
  assumes binding into grouped_irq_combiner, one clock domain.
*/
`timescale 1ns/1ns
module grouped_irq_combiner_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        stackFull,
  input wire logic        vectorAck,
  input wire logic        returnPlain,
  input wire logic        groupIrqReq,
  input wire logic        vectorReq,
  input wire logic [15:0] vectorAddr,
  input wire logic        wakeUp
);
  // ****************************************************************
  // vector handshake and wake-up checks
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_hold;
    vectorReq && !vectorAck |=> vectorReq;
  endproperty
  a_hold: assert property (p_hold)
    else $error("vector request dropped before ack");

  property p_drop;
    vectorReq && vectorAck |=> !vectorReq [*3];
  endproperty
  a_drop: assert property (p_drop)
    else $error("vector request kept or renewed after ack");

  property p_addr;
    vectorReq |-> vectorAddr == 16'h000C || vectorAddr == 16'h0010 ||
                  vectorAddr == 16'h0014;
  endproperty
  a_addr: assert property (p_addr)
    else $error("vector address outside the three group vectors");

  property p_stab;
    vectorReq && !vectorAck |=> $stable(vectorAddr);
  endproperty
  a_stab: assert property (p_stab)
    else $error("vector address moved during request");

  property p_full;
    $rose(vectorReq) |-> !$past(stackFull);
  endproperty
  a_full: assert property (p_full)
    else $error("vector raised with full stack");

  property p_cause;
    $rose(vectorReq) |-> $past(groupIrqReq);
  endproperty
  a_cause: assert property (p_cause)
    else $error("vector raised with no group request");

  property p_wake;
    $rose(groupIrqReq) |-> $past(wakeUp);
  endproperty
  a_wake: assert property (p_wake)
    else $error("group request rose without a wake-up");

  property p_plain;
    returnPlain |-> !vectorReq [*4];
  endproperty
  a_plain: assert property (p_plain)
    else $error("vector after plain return");
endmodule

bind grouped_irq_combiner grouped_irq_combiner_chk grouped_irq_combiner_chk_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .stackFull(stackFull),
  .vectorAck(vectorAck), .returnPlain(returnPlain),
  .groupIrqReq(groupIrqReq), .vectorReq(vectorReq),
  .vectorAddr(vectorAddr), .wakeUp(wakeUp)
);

//--- verif/core_seq_model.sv
/*
  processor core sequencer model: acks vectors, serves, returns.
  assumes vectorReq holds until acked.
*/
`timescale 1ns/1ns
module core_seq_model (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        vectorReq,
  input  wire logic [15:0] vectorAddr,
  input  wire logic        useReti,
  input  wire logic [3:0]  ackDelay,
  output logic             vectorAck,
  output logic             returnFromIrqInstr,
  output logic             returnPlain,
  output logic             serving,
  output logic      [15:0] lastVec
);
  logic [4:0] cnt; // wait and service cycle count
  // ack after ackDelay cycles, serve 17 cycles, then return
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {vectorAck, returnFromIrqInstr, returnPlain, serving} <= '0;
      cnt     <= '0;
      lastVec <= '0;
    end else begin
      vectorAck          <= 1'b0;
      returnFromIrqInstr <= 1'b0;
      returnPlain        <= 1'b0;
      if (!serving) begin
        if (vectorReq && !vectorAck && cnt == {1'b0, ackDelay}) begin
          vectorAck <= 1'b1;
          serving   <= 1'b1;
          lastVec   <= vectorAddr;
          cnt       <= '0;
        end else begin
          cnt <= vectorReq ? cnt + 5'd1 : '0;
        end
      end else if (cnt == 5'd16) begin
        // return kind picks whether global enable comes back
        serving <= 1'b0;
        cnt     <= '0;
        returnFromIrqInstr <= useReti;
        returnPlain        <= !useReti;
      end else begin
        cnt <= cnt + 5'd1;
      end
    end
  end
endmodule

//--- verif/grouped_irq_combiner_test.sv
/*
  self-checking bench: random member events plus corner cases.
  assumes core_seq_model as core and the cfg header constants.
*/
`timescale 1ns/1ns
`include "grouped_irq_cfg.svh"
module grouped_irq_combiner_test;
  logic sys_clk, arst_n, read, write, waitrequest, stackFull;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd, rnd;
  logic [3:0] byteenable, ackDelay;
  logic [2:0] timerPeriodMatch, timerCompareMatch;
  logic lowSupplyDetect, nvWriteDone, vectorAck, returnFromIrqInstr;
  logic returnPlain, groupIrqReq, vectorReq, wakeUp, irqOut;
  logic useReti, serving;
  logic [15:0] vectorAddr, lastVec;
  int n_mismatch, n_compared, m;

  grouped_irq_combiner grouped_irq_combiner_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .timerPeriodMatch(timerPeriodMatch),
    .timerCompareMatch(timerCompareMatch),
    .lowSupplyDetect(lowSupplyDetect), .nvWriteDone(nvWriteDone),
    .stackFull(stackFull), .vectorAck(vectorAck),
    .returnFromIrqInstr(returnFromIrqInstr), .returnPlain(returnPlain),
    .groupIrqReq(groupIrqReq), .vectorReq(vectorReq),
    .vectorAddr(vectorAddr), .wakeUp(wakeUp), .irqOut(irqOut));
  core_seq_model core_seq_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .vectorReq(vectorReq), .vectorAddr(vectorAddr), .useReti(useReti),
    .ackDelay(ackDelay), .vectorAck(vectorAck),
    .returnFromIrqInstr(returnFromIrqInstr),
    .returnPlain(returnPlain), .serving(serving), .lastVec(lastVec));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // member to group: period 0, compare 1, supply and nv 2
  function automatic int grp(input int k);
    return k < 3 ? 0 : (k < 6 ? 1 : 2);
  endfunction
  function automatic logic [31:0] mapv();
    mapv = '0;
    for (int k = 0; k < 8; k++) mapv |= 32'(grp(k)) << (2 * k);
  endfunction
  function automatic logic [31:0] vec(input int g);
    return 32'(`VEC_BASE + `VEC_STEP * g);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // avalon-mm access, request held until waitrequest low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    // waitrequest and read data taken as they stand at the edge
    do @(posedge sys_clk); while (waitrequest);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] p);
    @(posedge sys_clk);
    {nvWriteDone, lowSupplyDetect, timerCompareMatch, timerPeriodMatch} <= p;
    repeat (4) @(posedge sys_clk);
    {nvWriteDone, lowSupplyDetect, timerCompareMatch, timerPeriodMatch} <= 8'h00;
  endtask
  task automatic wait_vec(input int g);
    for (int k = 0; k < 40 && !serving; k++) @(negedge sys_clk);
    chk(32'(serving), 1);
    chk(32'(lastVec), vec(g));
  endtask
  task automatic wait_ret();
    for (int k = 0; k < 40 && serving; k++) @(negedge sys_clk);
    chk(32'(serving), 0);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    {arst_n, read, write, stackFull, lowSupplyDetect, nvWriteDone} = '0;
    {timerPeriodMatch, timerCompareMatch, address, writedata} = '0;
    byteenable = 4'hF;
    ackDelay   = 4'h1;
    useReti    = 1'b1;
    rnd        = 32'h0000_ec39;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    bus(0, `OFS_CTRL, 0);
    chk(rd, 0);
    bus(0, 8'h30, 0);
    chk(rd, 0);
    bus(1, `OFS_SRC_EN, 32'h0000_00FF);
    bus(1, `OFS_MAP, mapv());
    bus(1, `OFS_GRP_EN, 32'h0000_0007);
    bus(1, `OFS_CTRL, 32'h0000_0001);
    // random single member events, random ack delay and return kind
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      m   = int'(rnd[2:0]);
      useReti  <= rnd[3];
      ackDelay <= rnd[7:4];
      pins(8'(1 << m));
      wait_vec(grp(m));
      bus(0, `OFS_GRP_FLAG, 0);
      chk(rd, 0);
      bus(0, `OFS_CTRL, 0);
      chk(rd, 0);
      bus(0, `OFS_SRC_FLAG, 0);
      chk(32'(rd[m]), 1);
      wait_ret();
      bus(0, `OFS_CTRL, 0);
      chk(rd, 32'(useReti));
      if (!useReti) bus(1, `OFS_CTRL, 1);
      bus(1, `OFS_SRC_FLAG, 32'(1 << m));
    end
    // two groups at once: lowest index first
    useReti <= 1'b1;
    pins(8'h09);
    wait_vec(0);
    wait_ret();
    wait_vec(1);
    wait_ret();
    bus(1, `OFS_SRC_FLAG, 32'h0000_0009);
    // full stack holds the vector back, request still shown
    stackFull <= 1'b1;
    pins(8'h40);
    repeat (12) @(negedge sys_clk);
    chk(32'(serving), 0);
    chk(32'(groupIrqReq), 1);
    @(posedge sys_clk);
    stackFull <= 1'b0;
    wait_vec(2);
    wait_ret();
    bus(1, `OFS_SRC_FLAG, 32'h0000_0040);
    // disabled member: no group flag, but wake status and irq line
    bus(1, `OFS_WAKE_STAT, 1);
    bus(1, `OFS_SRC_EN, 32'h0000_007F);
    pins(8'h80);
    repeat (12) @(negedge sys_clk);
    chk(32'(serving), 0);
    bus(0, `OFS_GRP_FLAG, 0);
    chk(rd, 0);
    bus(0, `OFS_WAKE_STAT, 0);
    chk(32'(rd[0]), 1);
    bus(1, `OFS_WAKE_MASK, 1);
    @(negedge sys_clk);
    chk(32'(irqOut), 1);
    bus(1, `OFS_WAKE_STAT, 1);
    @(negedge sys_clk);
    chk(32'(irqOut), 0);
    bus(1, `OFS_SRC_FLAG, 32'h0000_0080);
    close_out();
  end
endmodule
